/* File: rtl/pfs_pkg.sv */
/*
  Constants for the per-channel gate pulse sequencer: register map, reset values,
  cycle counts and state encodings. Assumes a 20 MHz system clock.
  Notes on behaviour follow this header, above the package opening.
*/
// Notes on behaviour
// - Set pulse latch each cycle if control above half-volt
// - Clear latch when ramp exceeds control voltage
// - Control below half-volt keeps pulse low all cycle
// - Minimum on time, minimum off one twelfth
// - 128 fault cycles: float, discharge, wait 32768
// - Fault counter resets after 8-cycle clean gap
// - Reverse current blocks low drive, pulse every eight
// - Both run inputs low shuts everything down
// - Hold shared control low until all phases run
// - Undervoltage disables channel; resume when clear
// - Overvoltage forces pulse low until back in window, except during the nonsync cycles
// - Reverse current during overvoltage stops low drive
// - Float until start, then seven nonsynchronous cycles
// - Start needs no fault, no prebias, voltage high
// - Nonsync: high, short low pulse, then float
// - Nonsync sequence at start and every restart
// - Joined soft-start: restart all channels together
// - Prebias: flag, hold control low, float pulse
// - Clear prebias when ramp passes lower bound
// - Prebias above overvoltage drives pulse low
// - Driver enable low whenever pulse floats
// - Discharge soft-start on shutdown or fault
`default_nettype none
package pfs_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ            = 20_000_000;
  localparam int CLK_PERIOD_PS     = 1_000_000_000 / (CLK_HZ / 1000);
  localparam int MIN_ON_PS         = 20_000;
  localparam int NOC_PULSE_PS      = 20_000;
  // Least times round up, never below one cycle
  localparam int MIN_ON_CLKS       = (MIN_ON_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LOW_PULSE_CLKS    = (NOC_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MIN_OFF_DIVISOR   = 12;

  // ----------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------
  localparam logic [7:0] OC_TRIP_CYCLES   = 8'h80;
  localparam logic [3:0] OC_GAP_CYCLES    = 4'h7;
  localparam logic [2:0] NOC_EVERY_CYCLES = 3'h7;   // Counter wraps every eight
  localparam logic [2:0] NONSYNC_CYCLES   = 3'h7;
  localparam int         RETRY_CYCLES_DEF = 32768;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_ADDR   = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;
  localparam logic [7:0]  PERIOD_RST  = 8'h14;      // 1 MHz switching
  localparam logic [7:0]  PERIOD_MIN  = 8'h04;
  localparam int          ST_STATE_LSB = 0;
  localparam int          ST_PREBIAS   = 3;
  localparam int          ST_LATCH     = 4;
  localparam int          ST_DOWN      = 5;
  localparam int          ST_OCCNT_LSB = 8;

  // ----------------------------------------------------------------
  // Synchronised input positions
  // ----------------------------------------------------------------
  localparam int IN_RUN_A   = 0;
  localparam int IN_RUN_B   = 1;
  localparam int IN_RUN_ALL = 2;
  localparam int IN_UVLO    = 3;
  localparam int IN_RAMP    = 4;
  localparam int IN_CTRL    = 5;
  localparam int IN_TRACK   = 6;
  localparam int IN_OC      = 7;
  localparam int IN_NOC     = 8;
  localparam int IN_OV      = 9;
  localparam int IN_PBSET   = 10;
  localparam int IN_PBCLR   = 11;
  localparam int IN_W       = 12;

  typedef enum logic [2:0] {ST_OFF, ST_WAIT, ST_NONSYNC, ST_RUN, ST_RETRY} pfs_state_t;
  typedef enum logic [1:0] {DRV_HIZ, DRV_HIGH, DRV_LOW} pfs_drive_t;
endpackage
`default_nettype wire

/* File: rtl/pfs_sequencer.sv */
/*
  Gate pulse sequencer for one channel of a step-down controller, with APB registers.
  Assumes comparator outputs arrive as digital levels and the pad logic resolves the
  three-state gate pulse from drive value and active-low enable.
*/
// Added by the designer: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module pfs_sequencer #(
  parameter int RETRY_CYCLES = pfs_pkg::RETRY_CYCLES_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output var  logic [31:0] prdata_o,
  output var  logic        pready_o,
  output var  logic        pslverr_o,
  // Run and supply
  input  wire logic        channel_run_input_i,
  input  wire logic        other_run_input_i,
  input  wire logic        all_phases_run_i,
  input  wire logic        uvlo_i,
  // Comparators
  input  wire logic        ramp_above_ctrl_i,
  input  wire logic        ctrl_above_half_i,
  input  wire logic        track_above_580m_i,
  input  wire logic        overcurrent_fault_i,
  input  wire logic        reverse_current_fault_i,
  input  wire logic        overvoltage_fault_i,
  input  wire logic        feedback_above_ss_i,
  input  wire logic        ss_above_clear_i,
  // Outputs
  output var  logic        gate_pulse_out_o,
  output var  logic        gate_pulse_oe_n_o,
  output var  logic        driver_enable_out_o,
  output var  logic        ss_discharge_o,
  output var  logic        ctrl_hold_low_o,
  output var  logic        core_shutdown_o,
  output var  logic        prebias_flag_o
);

  function automatic logic [7:0] min_off_clks(input logic [7:0] period);
    logic [8:0] q;
    q = 9'((10'(period) + 10'(pfs_pkg::MIN_OFF_DIVISOR - 1)) / 10'(pfs_pkg::MIN_OFF_DIVISOR));
    min_off_clks = (q == 9'h000) ? 8'h01 : q[7:0];
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [pfs_pkg::IN_W-1:0] sync_a;
  logic [pfs_pkg::IN_W-1:0] sync_b;
  logic [pfs_pkg::IN_W-1:0] raw;
  assign raw = {ss_above_clear_i, feedback_above_ss_i, overvoltage_fault_i, reverse_current_fault_i,
                overcurrent_fault_i, track_above_580m_i, ctrl_above_half_i, ramp_above_ctrl_i,
                uvlo_i, all_phases_run_i, other_run_input_i, channel_run_input_i};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= raw;
      sync_b <= sync_a;
    end
  end

  logic run_a, run_b, run_all, uvlo, ramp, ctrl_half, track_ok, oc, reverse_current_fault, ov, pb_set, pb_clr;
  assign run_a     = sync_b[pfs_pkg::IN_RUN_A];
  assign run_b     = sync_b[pfs_pkg::IN_RUN_B];
  assign run_all   = sync_b[pfs_pkg::IN_RUN_ALL];
  assign uvlo      = sync_b[pfs_pkg::IN_UVLO];
  assign ramp      = sync_b[pfs_pkg::IN_RAMP];
  assign ctrl_half = sync_b[pfs_pkg::IN_CTRL];
  assign track_ok  = sync_b[pfs_pkg::IN_TRACK];
  assign oc        = sync_b[pfs_pkg::IN_OC];
  assign reverse_current_fault       = sync_b[pfs_pkg::IN_NOC];
  assign ov        = sync_b[pfs_pkg::IN_OV];
  assign pb_set    = sync_b[pfs_pkg::IN_PBSET];
  assign pb_clr    = sync_b[pfs_pkg::IN_PBCLR];

  logic down;
  assign down = !run_a || uvlo;

  // ----------------------------------------------------------------
  // Registers and APB
  // ----------------------------------------------------------------
  logic [7:0]          period;
  pfs_pkg::pfs_state_t state;
  logic                latch;
  logic                prebias;
  logic [7:0]          oc_cnt;
  logic                hit;
  logic                ctrl_hit;
  logic                stat_hit;
  logic [31:0]         rd_val;

  assign hit      = psel_i && penable_i && !pready_o;
  assign ctrl_hit = paddr_i == pfs_pkg::CTRL_ADDR;
  assign stat_hit = paddr_i == pfs_pkg::STATUS_ADDR;

  always_comb begin
    rd_val = 32'h0000_0000;
    if (ctrl_hit) begin
      rd_val[7:0] = period;
    end else if (stat_hit) begin
      rd_val[pfs_pkg::ST_STATE_LSB +: 3] = state;
      rd_val[pfs_pkg::ST_PREBIAS]        = prebias;
      rd_val[pfs_pkg::ST_LATCH]          = latch;
      rd_val[pfs_pkg::ST_DOWN]           = down;
      rd_val[pfs_pkg::ST_OCCNT_LSB +: 8] = oc_cnt;
    end
  end

  // One wait state: answer registered on the second access cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= hit;
      pslverr_o <= hit && !ctrl_hit && !stat_hit;
      prdata_o  <= (hit && !pwrite_i) ? rd_val : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      period <= pfs_pkg::PERIOD_RST;
    end else if (psel_i && penable_i && pready_o && pwrite_i && ctrl_hit) begin
      // Lands at the edge that completes the transfer, not at the wait state
      // Too short a period would leave no room for on and off times
      period <= (pwdata_i[7:0] < pfs_pkg::PERIOD_MIN) ? pfs_pkg::PERIOD_MIN : pwdata_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Switching cycle timebase
  // ----------------------------------------------------------------
  logic [7:0] phase;
  logic       cyc_start;
  logic [7:0] off_start;
  assign cyc_start = phase == 8'h00;
  assign off_start = period - min_off_clks(period);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase <= 8'h00;
    end else if (!run_a && !run_b) begin
      phase <= 8'h00;
    end else begin
      phase <= (phase >= period - 8'h01) ? 8'h00 : phase + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  logic [15:0] retry_cnt;
  logic [2:0]  ns_cnt;
  logic        start_ok;
  logic        oc_trip;
  logic        switching;
  // A prebias seen in the very clock of a cycle start must also block the start
  assign start_ok  = !oc && !prebias && !pb_set && (ctrl_half || track_ok) && run_all;
  assign switching = state == pfs_pkg::ST_NONSYNC || state == pfs_pkg::ST_RUN;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state     <= pfs_pkg::ST_OFF;
      retry_cnt <= 16'h0000;
      ns_cnt    <= 3'h0;
    end else if (down) begin
      state <= pfs_pkg::ST_OFF;
    end else begin
      unique case (state)
        pfs_pkg::ST_OFF: state <= pfs_pkg::ST_WAIT;
        pfs_pkg::ST_WAIT: begin
          if (cyc_start && start_ok) begin
            state  <= pfs_pkg::ST_NONSYNC;
            ns_cnt <= 3'h0;
          end
        end
        pfs_pkg::ST_NONSYNC: begin
          if (oc_trip) begin
            state     <= pfs_pkg::ST_RETRY;
            retry_cnt <= 16'h0000;
          end else if (cyc_start) begin
            ns_cnt <= ns_cnt + 3'h1;
            if (ns_cnt == pfs_pkg::NONSYNC_CYCLES - 3'h1) begin
              state <= pfs_pkg::ST_RUN;
            end
          end
        end
        pfs_pkg::ST_RUN: begin
          if (oc_trip) begin
            state     <= pfs_pkg::ST_RETRY;
            retry_cnt <= 16'h0000;
          end
        end
        pfs_pkg::ST_RETRY: begin
          if (cyc_start) begin
            if (retry_cnt == 16'(RETRY_CYCLES - 1)) begin
              state <= pfs_pkg::ST_WAIT;
            end else begin
              retry_cnt <= retry_cnt + 16'h0001;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Overcurrent counting with gap tolerance
  // ----------------------------------------------------------------
  logic       oc_seen;
  logic [3:0] gap_cnt;
  assign oc_trip = cyc_start && (oc_seen || oc) && oc_cnt == pfs_pkg::OC_TRIP_CYCLES - 8'h01;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oc_seen <= 1'b0;
      oc_cnt  <= 8'h00;
      gap_cnt <= 4'h0;
    end else if (!switching) begin
      oc_seen <= 1'b0;
      oc_cnt  <= 8'h00;
      gap_cnt <= 4'h0;
    end else if (cyc_start) begin
      oc_seen <= oc;
      if (oc_seen || oc) begin
        oc_cnt  <= oc_cnt + 8'h01;
        gap_cnt <= 4'h0;
      end else if (gap_cnt >= pfs_pkg::OC_GAP_CYCLES) begin
        oc_cnt <= 8'h00;
      end else begin
        gap_cnt <= gap_cnt + 4'h1;
      end
    end else begin
      oc_seen <= oc_seen || oc;
    end
  end

  // ----------------------------------------------------------------
  // Prebias flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prebias <= 1'b0;
    end else if (down) begin
      prebias <= 1'b0;
    end else if (state == pfs_pkg::ST_WAIT && pb_set) begin
      prebias <= 1'b1;
    end else if (pb_clr) begin
      prebias <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pulse latch
  // ----------------------------------------------------------------
  logic       latch_d1;
  logic [2:0] noc_cyc;
  logic       fell;
  logic       sw_start;
  assign fell     = latch_d1 && !latch;
  assign sw_start = cyc_start && (switching || (state == pfs_pkg::ST_WAIT && start_ok)) && !down;

  // A set at cycle start holds for at least one 50 ns clock, covering the minimum on time
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch <= 1'b0;
    end else if (sw_start && !oc_trip) begin
      latch <= ctrl_half;
    end else if (!switching || oc_trip) begin
      latch <= 1'b0;
    end else if (latch && (ramp || phase >= off_start)) begin
      latch <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_d1 <= 1'b0;
      noc_cyc  <= 3'h0;
    end else begin
      latch_d1 <= latch;
      if (cyc_start) begin
        noc_cyc <= (noc_cyc == pfs_pkg::NOC_EVERY_CYCLES) ? 3'h0 : noc_cyc + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output drive selection
  // ----------------------------------------------------------------
  pfs_pkg::pfs_drive_t next_drive;
  always_comb begin
    next_drive = pfs_pkg::DRV_HIZ;
    if (down) begin
      next_drive = pfs_pkg::DRV_HIZ;
    end else begin
      unique case (state)
        pfs_pkg::ST_OFF, pfs_pkg::ST_RETRY: next_drive = pfs_pkg::DRV_HIZ;
        pfs_pkg::ST_WAIT: begin
          // Prebias above the overvoltage point pulls down, protected by reverse current
          if (ov && !reverse_current_fault) begin
            next_drive = pfs_pkg::DRV_LOW;
          end else begin
            next_drive = pfs_pkg::DRV_HIZ;
          end
        end
        pfs_pkg::ST_NONSYNC: begin
          if (latch) begin
            next_drive = pfs_pkg::DRV_HIGH;
          end else if (fell) begin
            next_drive = pfs_pkg::DRV_LOW;
          end
        end
        pfs_pkg::ST_RUN: begin
          if (ov) begin
            next_drive = reverse_current_fault ? pfs_pkg::DRV_HIZ : pfs_pkg::DRV_LOW;
          end else if (latch) begin
            next_drive = pfs_pkg::DRV_HIGH;
          end else if (!reverse_current_fault || (fell && noc_cyc == 3'h0)) begin
            next_drive = pfs_pkg::DRV_LOW;
          end
        end
        default: next_drive = pfs_pkg::DRV_HIZ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_pulse_out_o    <= 1'b0;
      gate_pulse_oe_n_o   <= 1'b1;
      driver_enable_out_o <= 1'b0;
    end else begin
      gate_pulse_out_o    <= next_drive == pfs_pkg::DRV_HIGH;
      gate_pulse_oe_n_o   <= next_drive == pfs_pkg::DRV_HIZ;
      driver_enable_out_o <= next_drive != pfs_pkg::DRV_HIZ;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ss_discharge_o  <= 1'b1;
      ctrl_hold_low_o <= 1'b1;
      core_shutdown_o <= 1'b1;
      prebias_flag_o  <= 1'b0;
    end else begin
      ss_discharge_o  <= down || state == pfs_pkg::ST_RETRY || oc_trip;
      ctrl_hold_low_o <= down || !run_all || prebias;
      core_shutdown_o <= !run_a && !run_b;
      prebias_flag_o  <= prebias;
    end
  end

endmodule // pfs_sequencer
`default_nettype wire

/* File: verification/pfs_sequencer_props.sv */
/* Checker for the gate pulse sequencer, bound to its ports.
   Assumes 2-FF input synchronisers and registered outputs, so an input needs three edges to show. */
`timescale 1ns/100ps
`default_nettype none
module pfs_sequencer_props #(
  parameter int RETRY_CYCLES = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic channel_run_input_i,
  input wire logic other_run_input_i,
  input wire logic all_phases_run_i,
  input wire logic uvlo_i,
  input wire logic reverse_current_fault_i,
  input wire logic overvoltage_fault_i,
  input wire logic gate_pulse_out_o,
  input wire logic gate_pulse_oe_n_o,
  input wire logic driver_enable_out_o,
  input wire logic ss_discharge_o,
  input wire logic ctrl_hold_low_o,
  input wire logic core_shutdown_o,
  input wire logic prebias_flag_o
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // Four samples of a cause cover both synchroniser stages and the output register
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic drv_low = !gate_pulse_oe_n_o && !gate_pulse_out_o;

  property p_enable_follows; driver_enable_out_o != gate_pulse_oe_n_o; endproperty
  a_enable_follows: assert property (p_enable_follows) else $error("driver enable disagrees with float");
  property p_full_down; (!channel_run_input_i && !other_run_input_i) [*4] |-> core_shutdown_o; endproperty
  a_full_down: assert property (p_full_down) else $error("core not shut down with both runs low");
  property p_uvlo_off; uvlo_i [*4] |-> gate_pulse_oe_n_o && ss_discharge_o; endproperty
  a_uvlo_off: assert property (p_uvlo_off) else $error("channel active under undervoltage");
  property p_run_low; !channel_run_input_i [*4] |-> ss_discharge_o && gate_pulse_oe_n_o; endproperty
  a_run_low: assert property (p_run_low) else $error("soft-start kept while run low");
  property p_phase_hold; !all_phases_run_i [*4] |-> ctrl_hold_low_o; endproperty
  a_phase_hold: assert property (p_phase_hold) else $error("control released before all phases run");
  property p_rev_low; reverse_current_fault_i [*5] ##0 drv_low |=> !drv_low; endproperty
  a_rev_low: assert property (p_rev_low) else $error("low drive longer than one clock in reverse current");
  property p_ov_low; (overvoltage_fault_i && !reverse_current_fault_i) [*8] ##0 !gate_pulse_oe_n_o |-> !gate_pulse_out_o;
  endproperty
  a_ov_low: assert property (p_ov_low) else $error("pulse driven high in overvoltage");
  property p_prebias_float; (prebias_flag_o && !overvoltage_fault_i) [*4] |-> gate_pulse_oe_n_o; endproperty
  a_prebias_float: assert property (p_prebias_float) else $error("pulse driven during prebias");

  c_rev_pulse: cover property (drv_low && reverse_current_fault_i);
  c_prebias_ov: cover property (prebias_flag_o && !gate_pulse_oe_n_o);
  c_uvlo: cover property (uvlo_i && ss_discharge_o);
endmodule  // pfs_sequencer_props

bind pfs_sequencer pfs_sequencer_props #(.RETRY_CYCLES(RETRY_CYCLES)) u_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .channel_run_input_i(channel_run_input_i),
  .other_run_input_i(other_run_input_i), .all_phases_run_i(all_phases_run_i), .uvlo_i(uvlo_i),
  .reverse_current_fault_i(reverse_current_fault_i), .overvoltage_fault_i(overvoltage_fault_i),
  .gate_pulse_out_o(gate_pulse_out_o), .gate_pulse_oe_n_o(gate_pulse_oe_n_o),
  .driver_enable_out_o(driver_enable_out_o), .ss_discharge_o(ss_discharge_o),
  .ctrl_hold_low_o(ctrl_hold_low_o), .core_shutdown_o(core_shutdown_o), .prebias_flag_o(prebias_flag_o)
);
`default_nettype wire

/* File: verification/pfs_gate_driver_model.sv */
/* Gate driver model: resolves the three-state gate pulse and counts pad states per clock.
   Assumes the sequencer's registered drive value, active-low enable and driver enable. */
`timescale 1ns/100ps
`default_nettype none
module pfs_gate_driver_model (
  input  wire logic clk_i,
  input  wire logic clr_i,
  input  wire logic gate_pulse_out_i,
  input  wire logic gate_pulse_oe_n_i,
  input  wire logic driver_enable_i,
  output var  int   hi_o,
  output var  int   lo_o,
  output var  int   zlz_o
);
  // ----------------------------------------------------------------
  // Pad resolution and counting
  // ----------------------------------------------------------------
  wire logic  pad = gate_pulse_oe_n_i ? 1'hz : gate_pulse_out_i;
  logic [1:0] st;
  logic [1:0] st1 = 2'h0;
  logic [1:0] st2 = 2'h0;
  // A disabled driver keeps both switches off, whatever the pad shows
  always_comb st = (!driver_enable_i || pad === 1'hz) ? 2'h0 : (pad ? 2'h1 : 2'h2);
  always_ff @(posedge clk_i) begin
    st1 <= st;
    st2 <= st1;
    if (clr_i) begin
      hi_o  <= 0;
      lo_o  <= 0;
      zlz_o <= 0;
    end else begin
      hi_o  <= hi_o + int'(st == 2'h1);
      lo_o  <= lo_o + int'(st == 2'h2);
      // One-clock low pulse that ends in float; the clock before it is high or float, not low
      zlz_o <= zlz_o + int'(st2 != 2'h2 && st1 == 2'h2 && st == 2'h0);
    end
  end
endmodule  // pfs_gate_driver_model
`default_nettype wire

/* File: verification/tb_pfs_sequencer.sv */
/* Self-checking bench for the gate pulse sequencer with a gate driver model.
   Assumes a 20 MHz clock, a switching period of 8 clocks set over APB and a short retry wait. */
`timescale 1ns/100ps
`default_nettype none
module tb_pfs_sequencer;
  // ----------------------------------------------------------------
  // Stimulus, design and model
  // ----------------------------------------------------------------
  localparam int P = 8;
  logic        clk_i = 1'h0, rst_n_i = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0, clr = 1'h0, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, r;
  logic        run = 1'h0, orun = 1'h0, allrun = 1'h0, uvlo = 1'h0, ramp = 1'h0, half = 1'h0, track = 1'h0;
  logic        oc = 1'h0, rev = 1'h0, ov = 1'h0, fbss = 1'h0, ssclr = 1'h0;
  wire logic [31:0] prdata;
  wire logic   rdy, err, gate, oe_n, de, ssd, hold, shut, pb;
  int          hi, lo, zlz, error_cnt = 0, cmp_count = 0;

  pfs_sequencer #(.RETRY_CYCLES(4)) uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(rdy), .pslverr_o(err), .channel_run_input_i(run),
    .other_run_input_i(orun), .all_phases_run_i(allrun), .uvlo_i(uvlo), .ramp_above_ctrl_i(ramp),
    .ctrl_above_half_i(half), .track_above_580m_i(track), .overcurrent_fault_i(oc),
    .reverse_current_fault_i(rev), .overvoltage_fault_i(ov), .feedback_above_ss_i(fbss),
    .ss_above_clear_i(ssclr), .gate_pulse_out_o(gate), .gate_pulse_oe_n_o(oe_n), .driver_enable_out_o(de),
    .ss_discharge_o(ssd), .ctrl_hold_low_o(hold), .core_shutdown_o(shut), .prebias_flag_o(pb)
  );
  pfs_gate_driver_model u_drv (
    .clk_i(clk_i), .clr_i(clr), .gate_pulse_out_i(gate), .gate_pulse_oe_n_i(oe_n), .driver_enable_i(de),
    .hi_o(hi), .lo_o(lo), .zlz_o(zlz)
  );
  always #25 clk_i = ~clk_i;
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    report_and_stop();
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1'h1;
    do begin
      @(posedge clk_i);
      n++;
    end while (rdy !== 1'h1 && n < 16);
    if (n >= 16) error_cnt++;
    r = prdata;
    e = err;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  // Counts whole switching cycles, so the window phase does not matter
  task automatic win(input int cycles);
    clr <= 1'h1;
    cyc(1);
    clr <= 1'h0;
    // The extra edge lets the last counted edge settle before the read
    cyc(cycles * P + 1);
  endtask
  task automatic t_seq;
    // Ramp trips each cycle so the off time has room for the low pulse
    ramp <= 1'h1;
    win(14);
    chk("nonsync pulses", 7, zlz);
  endtask
  task automatic t_mode(input logic rp, hf, o, rv, input int cycles, ehi, elo);
    ramp <= rp;
    half <= hf;
    ov <= o;
    rev <= rv;
    cyc(3 * P);
    win(cycles);
    chk("high clocks", ehi, hi);
    chk("low clocks", elo, lo);
  endtask
  task automatic t_fault(input int gap);
    int n;
    n = 0;
    oc <= 1'h1;
    cyc(100 * P);
    oc <= 1'h0;
    cyc(gap * P);
    oc <= 1'h1;
    while (ssd !== 1'h1 && n < 200 * P) begin
      cyc(1);
      n++;
    end
    oc <= 1'h0;
    if (gap > 7) begin
      chk("trip after clean gap", 1'h1, n > 125 * P);
    end else begin
      chk("trip across short gap", 1'h1, n < 60 * P);
    end
    cyc(2);
    chk("fault float", 2'h2, {oe_n, de});
    n = 2;
    while (ssd === 1'h1 && n < 20 * P) begin
      cyc(1);
      n++;
    end
    chk("retry wait", 1'h1, n >= 3 * P && n <= 8 * P);
    t_seq();
  endtask
  task automatic t_prebias;
    run <= 1'h0;
    fbss <= 1'h1;
    cyc(4 * P);
    run <= 1'h1;
    cyc(4 * P);
    chk("prebias state", 3'h7, {pb, oe_n, hold});
    ov <= 1'h1;
    cyc(8);
    chk("prebias over ov", 2'h0, {oe_n, gate});
    ov <= 1'h0;
    fbss <= 1'h0;
    ssclr <= 1'h1;
    t_seq();
    chk("prebias cleared", 1'h0, pb);
  endtask
  task automatic t_shutdown;
    allrun <= 1'h0;
    cyc(5);
    chk("phase hold", 1'h1, hold);
    allrun <= 1'h1;
    cyc(5);
    chk("phase release", 1'h0, hold);
    uvlo <= 1'h1;
    cyc(5);
    chk("uvlo float", 2'h3, {oe_n, ssd});
    uvlo <= 1'h0;
    t_seq();
    run <= 1'h0;
    orun <= 1'h0;
    cyc(5);
    chk("shutdown", 3'h7, {shut, oe_n, ssd});
  endtask

  initial begin
    cyc(16);
    chk("reset float", 3'h4, {oe_n, de, pb});
    chk("reset discharge", 3'h7, {ssd, hold, shut});
    rst_n_i <= 1'h1;
    apb(1'h0, 12'h000, 32'h0);
    chk("period reset", 32'h14, r);
    apb(1'h1, 12'h000, 32'h2);
    apb(1'h0, 12'h000, 32'h0);
    chk("period floor", 32'h4, r);
    apb(1'h1, 12'h004, 32'hFF);
    chk("status write", 1'h0, e);
    apb(1'h0, 12'h004, 32'h0);
    chk("status idle", 3'h0, r[2:0]);
    apb(1'h0, 12'h008, 32'h0);
    chk("unmapped error", 1'h1, e);
    chk("unmapped data", 32'h0, r);
    apb(1'h1, 12'h000, P);
    run <= 1'h1;
    orun <= 1'h1;
    allrun <= 1'h1;
    half <= 1'h1;
    t_seq();
    apb(1'h0, 12'h004, 32'h0);
    chk("state run", 3'h3, r[2:0]);
    t_mode(1'h1, 1'h1, 1'h0, 1'h0, 4, 4, 28);
    t_mode(1'h1, 1'h1, 1'h0, 1'h1, 16, 16, 2);
    t_mode(1'h0, 1'h0, 1'h0, 1'h0, 4, 0, 32);
    t_mode(1'h0, 1'h1, 1'h1, 1'h0, 4, 0, 32);
    t_mode(1'h0, 1'h1, 1'h0, 1'h0, 4, 28, 4);
    t_fault(11);
    t_fault(5);
    t_prebias();
    t_shutdown();
    report_and_stop();
  end
endmodule  // tb_pfs_sequencer
`default_nettype wire
